// file: include/mcpwm_params.svh
// Purpose: Offsets, reset values and field positions of the PWM generator.
// Assumes: Included by the design file and by the testbench.
// Notes:   Register offsets are byte addresses on the AXI4-Lite bus.
`ifndef MCPWM_PARAMS_SVH
`define MCPWM_PARAMS_SVH

`define MCPWM_OFS_CTRL     12'h000
`define MCPWM_OFS_STATUS   12'h004
`define MCPWM_OFS_PRESCALE 12'h008
`define MCPWM_OFS_PERIOD   12'h00C
`define MCPWM_OFS_REPEAT   12'h010
`define MCPWM_OFS_INIT     12'h014
`define MCPWM_OFS_RESTORE  12'h018
`define MCPWM_OFS_CMP0     12'h020
`define MCPWM_OFS_TGL0     12'h040
`define MCPWM_CTRL_START   0
`define MCPWM_CTRL_STOP    1
`define MCPWM_RST_PRESCALE 8'h00
`define MCPWM_RST_PERIOD   16'h0000
`define MCPWM_RST_REPEAT   16'h0000
`define MCPWM_RST_MASK     8'h00
`define MCPWM_RESP_OKAY    2'b00
`define MCPWM_RESP_SLVERR  2'b10

`endif

// file: include/mcpwm_pkg.sv
// Purpose: Types shared by the PWM generator.
// Assumes: Eight channels and eight comparators.
// Notes:   Constants live in the params header.
package mcpwm_pkg;
    typedef logic [15:0] mcpwm_cnt_t;
    typedef logic [7:0]  mcpwm_mask_t;
endpackage

// file: rtl/mcpwm_top.sv
// Purpose: Eight-channel PWM generator with an AXI4-Lite register slave.
// Assumes: One clock, synchronous active-low reset, single-beat AXI4-Lite.
// Notes:   Outputs change only on prescaler ticks or on start; stop holds them.
// Behaviour
// - Eight independent PWM outputs, each with its own signal.
// - One shared programmable prescaler divides the system clock to a tick.
// - One shared 16-bit counter advanced by each tick sets the period.
// - Counter counts up to the programmed period value inclusive, then restarts.
// - Eight shared 16-bit comparators, each holding a programmed value.
// - Any channel may use up to eight comparators, one toggle each.
// - Counter matching an assigned comparator inverts that channel output.
// - Two comparators on one channel give a single duty-cycle pulse.
// - Shared repeat count limits how many periods are generated.
// - Per-output toggle enable mask selects which comparators may toggle.
// - Initial-state mask sets each output's starting level.
// - Restore mask returns selected outputs to initial level each period end.
// - Prescaler value FF divides the system clock by 256.
`include "mcpwm_params.svh"
module mcpwm_top
    import mcpwm_pkg::*;
#(
    parameter int NCH = 8
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [NCH-1:0]   pwmOut
);

    typedef struct packed {
        logic                awFull;
        logic [11:0]         awAddr;
        logic                wFull;
        logic [31:0]         wData;
        logic [3:0]          wStrb;
        logic                bValid;
        logic [1:0]          bResp;
        logic                rValid;
        logic [31:0]         rData;
        logic [1:0]          rResp;
        logic [7:0]          prescale;
        logic [7:0]          preCnt;
        mcpwm_cnt_t          period;
        mcpwm_cnt_t          count;
        mcpwm_cnt_t          repeatCnt;
        mcpwm_cnt_t          doneCnt;
        logic                running;
        mcpwm_mask_t         initMask;
        mcpwm_mask_t         restoreMask;
        mcpwm_cnt_t [7:0]    cmp;
        mcpwm_mask_t [NCH-1:0] tglEn;
        logic [NCH-1:0]      pwm;
    } mcpwm_state_s;

    mcpwm_state_s st;
    mcpwm_state_s next_st;

    // Merges a write word into a register under the byte strobes.
    function automatic logic [31:0] mcpwm_merge(input logic [31:0] old,
                                                input logic [31:0] dat,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = dat[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Byte address of an indexed word in a register bank.
    function automatic logic [11:0] mcpwm_slot(input logic [11:0] base,
                                               input int          idx);
        return base + 12'(idx * 4);
    endfunction

    // One process computes the whole next state; software writes win
    // over the engine in the same cycle because they are applied last.
    always_comb begin
        logic [31:0] wv;
        logic        tick;
        logic        wrap;
        logic [7:0]  match;
        logic        okW;
        logic        okR;
        wv      = 32'h0000_0000;
        next_st = st;
        okW     = 1'b0;
        okR     = 1'b0;
        tick    = 1'b0;
        wrap    = 1'b0;
        match   = 8'h00;
        // Prescaler: a reload of N divides by N+1, so FF gives 256.
        tick = st.running && (st.preCnt == st.prescale);
        wrap = tick && (st.count >= st.period);
        if (st.running) begin
            next_st.preCnt = tick ? 8'h00 : st.preCnt + 8'h01;
        end
        // Comparator matches are shared by all channels.
        for (int c = 0; c < 8; c++) begin
            match[c] = tick && (st.count == st.cmp[c]);
        end
        if (tick) begin
            next_st.count = wrap ? 16'h0000 : st.count + 16'h0001;
            for (int ch = 0; ch < NCH; ch++) begin
                // Parity of enabled matches; equal comparators can match together and cancel.
                if (^(match & st.tglEn[ch])) begin
                    next_st.pwm[ch] = ~st.pwm[ch];
                end
                if (wrap && st.restoreMask[ch]) begin
                    next_st.pwm[ch] = st.initMask[ch];
                end
            end
            if (wrap) begin
                next_st.doneCnt = st.doneCnt + 16'h0001;
                // A repeat count of zero means run without limit.
                if (st.repeatCnt != 16'h0000 &&
                    st.doneCnt + 16'h0001 >= st.repeatCnt) begin
                    next_st.running = 1'b0;
                end
            end
        end
        // Write channel: address and data are caught in either order.
        if (s_axi_awvalid && !st.awFull) begin
            next_st.awFull = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.wFull) begin
            next_st.wFull = 1'b1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end
        if (st.bValid && s_axi_bready) begin
            next_st.bValid = 1'b0;
        end
        if (st.awFull && st.wFull && !st.bValid) begin
            next_st.awFull = 1'b0;
            next_st.wFull  = 1'b0;
            next_st.bValid = 1'b1;
            okW = 1'b1;
            unique case (st.awAddr)
                `MCPWM_OFS_CTRL: begin
                    wv = st.wData & {28'h000_0000, st.wStrb[0] ? 4'hF : 4'h0};
                    if (wv[`MCPWM_CTRL_START]) begin
                        // Start reloads outputs from the initial mask.
                        next_st.running = 1'b1;
                        next_st.count   = 16'h0000;
                        next_st.preCnt  = 8'h00;
                        next_st.doneCnt = 16'h0000;
                        next_st.pwm     = st.initMask;
                    end
                    if (wv[`MCPWM_CTRL_STOP]) begin
                        next_st.running = 1'b0;
                    end
                end
                `MCPWM_OFS_PRESCALE: begin
                    wv = mcpwm_merge({24'h00_0000, st.prescale},
                                     st.wData, st.wStrb);
                    next_st.prescale = wv[7:0];
                end
                `MCPWM_OFS_PERIOD: begin
                    wv = mcpwm_merge({16'h0000, st.period},
                                     st.wData, st.wStrb);
                    next_st.period = wv[15:0];
                end
                `MCPWM_OFS_REPEAT: begin
                    wv = mcpwm_merge({16'h0000, st.repeatCnt},
                                     st.wData, st.wStrb);
                    next_st.repeatCnt = wv[15:0];
                end
                `MCPWM_OFS_INIT: begin
                    wv = mcpwm_merge({24'h00_0000, st.initMask},
                                     st.wData, st.wStrb);
                    next_st.initMask = wv[7:0];
                end
                `MCPWM_OFS_RESTORE: begin
                    wv = mcpwm_merge({24'h00_0000, st.restoreMask},
                                     st.wData, st.wStrb);
                    next_st.restoreMask = wv[7:0];
                end
                default: begin
                    okW = 1'b0;
                    for (int i = 0; i < 8; i++) begin
                        if (st.awAddr == mcpwm_slot(`MCPWM_OFS_CMP0, i)) begin
                            wv = mcpwm_merge({16'h0000, st.cmp[i]},
                                             st.wData, st.wStrb);
                            next_st.cmp[i] = wv[15:0];
                            okW = 1'b1;
                        end
                    end
                    for (int i = 0; i < NCH; i++) begin
                        if (st.awAddr == mcpwm_slot(`MCPWM_OFS_TGL0, i)) begin
                            wv = mcpwm_merge({24'h00_0000, st.tglEn[i]},
                                             st.wData, st.wStrb);
                            next_st.tglEn[i] = wv[7:0];
                            okW = 1'b1;
                        end
                    end
                end
            endcase
            next_st.bResp = okW ? `MCPWM_RESP_OKAY : `MCPWM_RESP_SLVERR;
        end
        // Read channel: one read at a time, answered the next cycle.
        if (st.rValid && s_axi_rready) begin
            next_st.rValid = 1'b0;
        end
        if (s_axi_arvalid && !st.rValid) begin
            next_st.rValid = 1'b1;
            next_st.rData  = 32'h0000_0000;
            okR = 1'b1;
            unique case (s_axi_araddr)
                `MCPWM_OFS_CTRL:     next_st.rData = 32'h0000_0000;
                `MCPWM_OFS_STATUS:   next_st.rData = {7'h00, st.running,
                                                      st.pwm, st.count};
                `MCPWM_OFS_PRESCALE: next_st.rData[7:0]  = st.prescale;
                `MCPWM_OFS_PERIOD:   next_st.rData[15:0] = st.period;
                `MCPWM_OFS_REPEAT:   next_st.rData[15:0] = st.repeatCnt;
                `MCPWM_OFS_INIT:     next_st.rData[7:0]  = st.initMask;
                `MCPWM_OFS_RESTORE:  next_st.rData[7:0]  = st.restoreMask;
                default: begin
                    okR = 1'b0;
                    for (int i = 0; i < 8; i++) begin
                        if (s_axi_araddr ==
                            mcpwm_slot(`MCPWM_OFS_CMP0, i)) begin
                            next_st.rData[15:0] = st.cmp[i];
                            okR = 1'b1;
                        end
                    end
                    for (int i = 0; i < NCH; i++) begin
                        if (s_axi_araddr ==
                            mcpwm_slot(`MCPWM_OFS_TGL0, i)) begin
                            next_st.rData[7:0] = st.tglEn[i];
                            okR = 1'b1;
                        end
                    end
                end
            endcase
            next_st.rResp = okR ? `MCPWM_RESP_OKAY : `MCPWM_RESP_SLVERR;
        end
    end

    // Reset clears the counter and forces every output low.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st             <= '0;
            st.prescale    <= `MCPWM_RST_PRESCALE;
            st.period      <= `MCPWM_RST_PERIOD;
            st.repeatCnt   <= `MCPWM_RST_REPEAT;
            st.initMask    <= `MCPWM_RST_MASK;
            st.restoreMask <= `MCPWM_RST_MASK;
        end else begin
            st <= next_st;
        end
    end

    // All outputs come straight from the state register.
    assign s_axi_awready = !st.awFull;
    assign s_axi_wready  = !st.wFull;
    assign s_axi_bvalid  = st.bValid;
    assign s_axi_bresp   = st.bResp;
    assign s_axi_arready = !st.rValid;
    assign s_axi_rvalid  = st.rValid;
    assign s_axi_rdata   = st.rData;
    assign s_axi_rresp   = st.rResp;
    assign pwmOut        = st.pwm;

endmodule

// file: verification/mcpwm_chk.sv
// Purpose: Assertions on the ports of the PWM generator.
// Assumes: One clock; bound to every instance of the top module.
// Notes:   The reset checks run without a disable condition on purpose.
module mcpwm_chk
    import mcpwm_pkg::*;
#(
    parameter int NCH = 8
) (
    input wire logic           clk,
    input wire logic           rst_n,
    input wire logic           s_axi_awvalid,
    input wire logic           s_axi_awready,
    input wire logic           s_axi_wvalid,
    input wire logic           s_axi_wready,
    input wire logic [1:0]     s_axi_bresp,
    input wire logic           s_axi_bvalid,
    input wire logic           s_axi_bready,
    input wire logic           s_axi_arvalid,
    input wire logic           s_axi_arready,
    input wire logic [31:0]    s_axi_rdata,
    input wire logic           s_axi_rvalid,
    input wire logic           s_axi_rready,
    input wire logic [NCH-1:0] pwmOut
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    // This sequence covers only writes whose address and data are taken in the same cycle.
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_RST_OUT: assert property (!rst_n |=> pwmOut == '0)
        else $error("outputs not low after reset");
    AST_RST_BUS: assert property (
        !rst_n |=> !s_axi_bvalid && s_axi_arready)
        else $error("bus not idle after reset");
    AST_WR_ANS: assert property (
        disable iff (!rst_n) wrTaken |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    AST_RD_ANS: assert property (
        disable iff (!rst_n) rdTaken |=> s_axi_rvalid)
        else $error("read answer late");
    AST_BV_HOLD: assert property (disable iff (!rst_n)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    AST_RV_HOLD: assert property (disable iff (!rst_n)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    AST_RV_DONE: assert property (disable iff (!rst_n)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##[0:1] s_axi_arready)
        else $error("read slot not freed");
    AST_BV_DONE: assert property (disable iff (!rst_n)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not withdrawn");
endmodule
bind mcpwm_top mcpwm_chk #(.NCH(NCH)) chk (.*);

// file: verification/mcpwm_load.sv
// Purpose: Load model for the PWM outputs, like a bridge input stage.
// Assumes: Outputs are sampled on the system clock.
// Notes:   Pulse widths are counted in clocks, not in prescaled ticks.
module mcpwm_load #(
    parameter int NCH = 8
) (
    input wire logic           clk,
    input wire logic           clr,
    input wire logic [NCH-1:0] pwm,
    output int                 riseCnt [NCH],
    output int                 highCnt [NCH]
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NCH-1:0] last = '0;
    // A bridge only sees levels, so edges and on-time are what we keep.
    always @(posedge clk) begin
        last <= pwm;
        for (int i = 0; i < NCH; i++) begin
            riseCnt[i] <= clr ? 0 : riseCnt[i] + int'(pwm[i] & ~last[i]);
            highCnt[i] <= clr ? 0 : highCnt[i] + int'(pwm[i]);
        end
    end
endmodule

// file: verification/test_multi_channel_pwm_generator.sv
// Purpose: Register-driven tests of the PWM generator.
// Assumes: The slave may answer late, so both bus tasks wait for handshakes.
// Notes:   Pulse counts come from the load model on the outputs.
`include "mcpwm_params.svh"
module test_multi_channel_pwm_generator
    import mcpwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, loadClr = 1'b1;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
    logic arValid = 1'b0, rReady = 1'b0, awReady, wReady, bValid;
    logic arReady, rValid;
    logic [11:0] awAddr = '0, arAddr = '0;
    logic [31:0] wData = '0, rData, rdVal, held;
    logic [1:0] bResp, rResp, lastResp;
    mcpwm_mask_t pwmOut;
    int riseCnt [8], highCnt [8], fail_count = 0, n_compared = 0;
    logic [15:0] cmpTab [8] = '{16'h0007, 16'h0008, 16'h000C, 16'h000E,
                                16'h000F, 16'h0010, 16'h0013, 16'h0016};
    mcpwm_top dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .pwmOut(pwmOut));
    mcpwm_load #(.NCH(8)) load (.clk(clk), .clr(loadClr), .pwm(pwmOut),
        .riseCnt(riseCnt), .highCnt(highCnt));
    // Free-running system clock.
    initial forever #20 clk = ~clk;
    // Each channel is released at its own ready; bready stands from the
    // start, so the answer is taken at the very edge it is first seen.
    task automatic axiWr(input logic [11:0] a, input logic [31:0] d);
        bit aPend = 1, wPend = 1;
        @(posedge clk);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do begin
            @(posedge clk);
            if (aPend && awReady) begin
                awValid <= 1'b0;
                aPend = 0;
            end
            if (wPend && wReady) begin
                wValid <= 1'b0;
                wPend = 0;
            end
        end while (aPend || wPend || !bValid);
        lastResp = bResp;
        bReady <= 1'b0;
    endtask
    // Read: rready stands until rvalid is sampled, data taken at that edge.
    task automatic axiRd(input logic [11:0] a);
        bit aPend = 1;
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            @(posedge clk);
            if (aPend && arReady) begin
                arValid <= 1'b0;
                aPend = 0;
            end
        end while (aPend || !rValid);
        rdVal = rData;
        lastResp = rResp;
        rReady <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // The whole run is about 1360 cycles; a hang ends it as a failure.
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        wrap_up();
    end
    // Main sequence: reset, unmapped access, multi-pulse run, slow run.
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        loadClr <= 1'b0;
        @(posedge clk);
        chk(pwmOut, 32'h0000_0000);
        axiRd(`MCPWM_OFS_PERIOD);
        chk(rdVal, 32'h0000_0000);
        axiWr(12'hFFC, 32'h0000_0001);
        chk(lastResp, `MCPWM_RESP_SLVERR);
        axiRd(12'hFFC);
        chk(lastResp, `MCPWM_RESP_SLVERR);
        chk(rdVal, 32'h0000_0000);
        for (int i = 0; i < 8; i++)
            axiWr(`MCPWM_OFS_CMP0 + 12'(4 * i), 32'(cmpTab[i]));
        axiWr(`MCPWM_OFS_PERIOD, 32'h0000_0017);
        axiWr(`MCPWM_OFS_REPEAT, 32'h0000_0002);
        axiWr(`MCPWM_OFS_TGL0, 32'h0000_00FF);
        axiWr(`MCPWM_OFS_TGL0 + 12'h004, 32'h0000_0003);
        axiWr(`MCPWM_OFS_CTRL, 32'h0000_0001);
        repeat (70) @(posedge clk);
        chk(riseCnt[0], 8);
        chk(highCnt[0], 14);
        chk(riseCnt[1], 2);
        chk(highCnt[1], 2);
        chk(riseCnt[2], 0);
        axiRd(`MCPWM_OFS_STATUS);
        chk(rdVal[24], 1'b0);
        axiWr(`MCPWM_OFS_CMP0, 32'h0000_0001);
        axiWr(`MCPWM_OFS_CMP0 + 12'h004, 32'h0000_0002);
        axiWr(`MCPWM_OFS_TGL0 + 12'h008, 32'h0000_0003);
        axiWr(`MCPWM_OFS_TGL0 + 12'h00C, 32'h0000_0001);
        axiWr(`MCPWM_OFS_TGL0 + 12'h010, 32'h0000_0001);
        axiWr(`MCPWM_OFS_INIT, 32'h0000_0004);
        axiWr(`MCPWM_OFS_RESTORE, 32'h0000_0008);
        axiWr(`MCPWM_OFS_PRESCALE, 32'h0000_00FF);
        axiWr(`MCPWM_OFS_PERIOD, 32'h0000_0003);
        axiWr(`MCPWM_OFS_REPEAT, 32'h0000_0001);
        loadClr <= 1'b1;
        @(posedge clk);
        loadClr <= 1'b0;
        axiWr(`MCPWM_OFS_CTRL, 32'h0000_0001);
        repeat (1100) @(posedge clk);
        chk(highCnt[0], 256);
        chk(riseCnt[2], 2);
        chk(pwmOut, 32'h0000_0014);
        axiRd(`MCPWM_OFS_STATUS);
        chk(rdVal[24:16], 9'h014);
        // A zero repeat count runs on; a stop freezes count and outputs.
        axiWr(`MCPWM_OFS_REPEAT, 32'h0000_0000);
        axiWr(`MCPWM_OFS_PRESCALE, 32'h0000_0000);
        axiWr(`MCPWM_OFS_CTRL, 32'h0000_0001);
        repeat (20) @(posedge clk);
        axiRd(`MCPWM_OFS_STATUS);
        chk(rdVal[24], 1'b1);
        axiWr(`MCPWM_OFS_CTRL, 32'h0000_0002);
        axiRd(`MCPWM_OFS_STATUS);
        held = rdVal;
        repeat (10) @(posedge clk);
        axiRd(`MCPWM_OFS_STATUS);
        chk(rdVal, held);
        chk(held[24], 1'b0);
        wrap_up();
    end
endmodule
